// ---- pkg/tma_defs.vh ----
`ifndef TMA_DEFS_VH
`define TMA_DEFS_VH
// ============================================================
// Register byte offsets (one aligned word each)
`define TMA_SC_OFS    8'h00
`define TMA_CNT_OFS   8'h04
`define TMA_MODH_OFS  8'h08
`define TMA_MODL_OFS  8'h0C
// Channel n lives in slot n+1 of 0x10 bytes: haddr[6:4] = n+1
`define TMA_CH_SLOT0  3'h1
`define TMA_CSC_SUB   2'h0
`define TMA_CHH_SUB   2'h1
`define TMA_CHL_SUB   2'h2
// ============================================================
// Timer status/control fields
`define TMA_SC_FLAG   7
`define TMA_SC_OIE    6
`define TMA_SC_HALT   5
`define TMA_SC_CLR    4
`define TMA_PS_MSB    2
`define TMA_PS_LSB    0
`define TMA_PS_EXT    3'h7
// ============================================================
// Channel status/control fields
`define TMA_CSC_FLAG  7
`define TMA_CSC_IE    6
`define TMA_CSC_BUF   5
`define TMA_CSC_UNB   4
`define TMA_CSC_ELSH  3
`define TMA_CSC_ELSL  2
`define TMA_CSC_TOV   1
`define TMA_CSC_MAX   0
// Edge/level codes
`define TMA_ELS_TOG   2'h1
`define TMA_ELS_CLR   2'h2
`define TMA_ELS_SET   2'h3
// ============================================================
// Reset values
`define TMA_HALT_RST  1'b1
`define TMA_PS_RST    3'h0
`define TMA_MOD_RST   16'hFFFF
`define TMA_CSC_RST   7'h00
`define TMA_VAL_RST   16'h0000
`endif

// ---- hdl/tma_sync.v ----
`timescale 1ns/1ps
// ============================================================
// Pin synchroniser: four flops, a change counts once the
// second and third agree, which also rejects one-cycle glitches
module tma_sync #(
   parameter W = 7
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rstn,
   // Raw pins and filtered levels
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg  [W-1:0] s1_reg;
   reg  [W-1:0] s2_reg;
   reg  [W-1:0] s3_reg;
   reg  [W-1:0] f_reg;
   wire [W-1:0] agree = ~(s2_reg ^ s3_reg);

   // s1 feeds s2 only, to keep metastability away from logic
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
         s3_reg <= {W{1'b0}};
         f_reg  <= {W{1'b0}};
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         f_reg  <= (s2_reg & agree) | (f_reg & ~agree);
      end
   end

   assign q = f_reg;
endmodule // tma_sync

// ---- hdl/tma_chan.v ----
`timescale 1ns/1ps
`include "tma_defs.vh"
// ============================================================
// One timer channel: compare output, overflow toggle, capture
module tma_chan (
   // Clock and reset
   input  wire        clk,
   input  wire        rstn,
   // Configuration
   input  wire        oc_en,
   input  wire        ic_en,
   input  wire [1:0]  els,
   input  wire        tov,
   input  wire        full,
   // Counter events
   input  wire        upd,
   input  wire        wrap,
   input  wire [15:0] cnt,
   input  wire [15:0] cmp,
   input  wire        cmp_ok,
   // Pin and capture control
   input  wire        pin_f,
   input  wire        cap_blk,
   output wire        pin_out,
   output wire        evt,
   output wire        cap
);
   reg  out_reg;
   reg  evt_reg;
   reg  pin_q_reg;
   wire hit  = oc_en & upd & cmp_ok & (cnt == cmp);
   wire rise = pin_f & ~pin_q_reg;
   wire fall = ~pin_f & pin_q_reg;

   // Capture on the chosen edge, held off while the counter is frozen
   assign cap = ic_en & ~cap_blk & ((els[0] & rise) | (els[1] & fall));

   // Output state and event pulse
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_reg   <= 1'b0;
         evt_reg   <= 1'b0;
         pin_q_reg <= 1'b0;
      end else begin
         pin_q_reg <= pin_f;
         evt_reg   <= hit | cap; // RULE14
         if (!oc_en) begin
            out_reg <= 1'b0;
         end else if (full && tov) begin
            out_reg <= ~els[0]; // RULE12
         end else if (hit) begin
            // Forcing the level already present changes nothing
            case (els)
               `TMA_ELS_TOG: out_reg <= ~out_reg;
               `TMA_ELS_CLR: out_reg <= 1'b0; // RULE7 RULE11
               `TMA_ELS_SET: out_reg <= 1'b1; // RULE7
               default:      out_reg <= out_reg;
            endcase
         end else if (wrap && tov) begin
            out_reg <= ~out_reg; // RULE11
         end
      end
   end

   assign pin_out = out_reg;
   assign evt     = evt_reg;
endmodule // tma_chan

// ---- hdl/tma_top.v ----
`timescale 1ns/1ps
`include "tma_defs.vh"
// ============================================================
// Overview of operation
// RULE1 - Channels 0/1, 2/3, 4/5 link into pairs driving the even pin
// RULE2 - On linking, the even channel's compare value sets the width
// RULE3 - Last written pair channel takes control at each overflow
// RULE4 - Linked pair uses even control register; odd pin released
// RULE5 - Software writes new widths only to the idle channel
// RULE6 - Mode field 0:1 unbuffered, 1:0 buffered compare or PWM
// RULE7 - Edge/level 1:0 clears output on compare, 1:1 sets it
// RULE8 - Software halts, clears, sets limit, width, modes, then runs
// RULE9 - Software avoids toggle-on-compare for PWM
// RULE10 - Buffered link bit wins over the unbuffered mode bit
// RULE11 - Toggle-on-wrap cleared gives a 0% duty output
// RULE12 - Full duty plus toggle-on-wrap gives 100% duty output
// RULE13 - Overflow flag sets at the period limit; interrupt if enabled
// RULE14 - Channel flag sets on capture or compare; interrupt if enabled
// RULE15 - Wait mode keeps counting, blocks bus access, irq wakes CPU
// RULE16 - Stop mode freezes the timer but keeps all state
// RULE17 - Debug break halts counter and suppresses captures
// RULE18 - Break clears status bits only with the clear permit set
// RULE19 - Armed clear is held during break and completes afterwards
// RULE20 - External count clock pin and six shared channel pins
// RULE21 - Overflow flag clears by read-while-set then write 0
// RULE22 - Prescale codes divide by 1..64, code 111 picks the pin
// RULE23 - Reset halts counter; clear bit zeroes counter, reads 0
// RULE24 - Wrap at limit; limit high write blocks flag until low write
// RULE25 - Compare write completes only when its low byte is written
module tma_top #(
   parameter NCH = 6,
   parameter PSW = 7
) (
   // Clock and reset
   input  wire           hclk,
   input  wire           hresetn,
   // AHB-Lite slave
   input  wire           hsel,
   input  wire [31:0]    haddr,
   input  wire [1:0]     htrans,
   input  wire           hwrite,
   input  wire [2:0]     hsize,
   input  wire [31:0]    hwdata,
   input  wire           hready,
   output wire           hreadyout,
   output wire [31:0]    hrdata,
   output wire           hresp,
   // System state
   input  wire           wait_mode,
   input  wire           stop_mode,
   input  wire           debug_break,
   input  wire           break_clear_permit,
   // Interrupt requests
   output wire           overflow_irq,
   output wire [NCH-1:0] channel_irq,
   output wire           timer_irq,
   // Pins
   input  wire           ext_count_clock_pin,
   input  wire [NCH-1:0] chan_pin_in,
   output wire [NCH-1:0] chan_pin_out,
   output wire [NCH-1:0] chan_pin_oe
);
   localparam NP  = NCH / 2;
   localparam OVF = NCH;

   // ============================================================
   // Address and prescaler helpers
   function ch_ok;
      input [7:0] a;
      begin
         ch_ok = ~a[7] & (a[6:4] != 3'h0) & ({29'd0, a[6:4]} <= NCH)
               & (a[3:2] != 2'h3) & (a[1:0] == 2'h0);
      end
   endfunction

   function [2:0] ch_of;
      input [7:0] a;
      begin
         ch_of = a[6:4] - `TMA_CH_SLOT0;
      end
   endfunction

   function [PSW-1:0] ps_mask;
      input [2:0] ps;
      begin
         ps_mask = ({{(PSW-1){1'b0}}, 1'b1} << ps) - {{(PSW-1){1'b0}}, 1'b1};
      end
   endfunction

   // ============================================================
   // Bus phases
   reg         dsel_reg;
   reg  [7:0]  dadr_reg;
   reg  [31:0] hrdata_reg;
   reg  [31:0] rd_next;
   // CPU cannot reach the registers in wait mode
   wire        acc  = hsel & htrans[1] & hready & ~wait_mode // RULE15
                    & (haddr[31:8] == 24'h000000);
   wire        rd_a = acc & ~hwrite;
   wire [7:0]  ra   = haddr[7:0];
   wire [2:0]  rci  = ch_of(ra);
   wire        rch  = rd_a & ch_ok(ra);
   wire [2:0]  wci  = ch_of(dadr_reg);
   wire        wch  = dsel_reg & ch_ok(dadr_reg);
   wire        w_sc   = dsel_reg & (dadr_reg == `TMA_SC_OFS);
   wire        w_modh = dsel_reg & (dadr_reg == `TMA_MODH_OFS);
   wire        w_modl = dsel_reg & (dadr_reg == `TMA_MODL_OFS);
   wire        w_csc  = wch & (dadr_reg[3:2] == `TMA_CSC_SUB);
   wire        w_chh  = wch & (dadr_reg[3:2] == `TMA_CHH_SUB);
   wire        w_chl  = wch & (dadr_reg[3:2] == `TMA_CHL_SUB);

   // ============================================================
   // Counter, prescaler and limit
   reg            halt_reg;
   reg            oie_reg;
   reg  [2:0]     ps_reg;
   reg  [15:0]    cnt_reg;
   reg  [15:0]    mod_reg;
   reg            mod_inh_reg;
   reg  [PSW-1:0] pre_reg;
   reg            ext_q_reg;
   reg            upd_reg;
   reg            wrap_reg;
   wire [NCH:0]   pin_f;
   wire           ext_f  = pin_f[OVF];
   wire           clr    = w_sc & hwdata[`TMA_SC_CLR]; // RULE23
   // Halt, stop and break all freeze counting
   wire           run    = ~halt_reg & ~stop_mode & ~debug_break; // RULE16 RULE17
   wire [PSW-1:0] msk    = ps_mask(ps_reg);
   wire           pre_hit = (ps_reg == `TMA_PS_EXT) ? (ext_f & ~ext_q_reg) // RULE22
                          : ((pre_reg & msk) == msk);
   wire           tick   = run & pre_hit;
   wire           at_lim = (cnt_reg == mod_reg);

   // Pins pass the four-flop filter before any use
   tma_sync #(
      .W (NCH + 1)
   ) u_sync (
      .clk  (hclk),
      .rstn (hresetn),
      .d    ({ext_count_clock_pin, chan_pin_in}), // RULE20
      .q    (pin_f)
   );

   // Timer control, counter and limit registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         halt_reg    <= `TMA_HALT_RST; // RULE23
         oie_reg     <= 1'b0;
         ps_reg      <= `TMA_PS_RST;
         cnt_reg     <= 16'h0000;
         mod_reg     <= `TMA_MOD_RST;
         mod_inh_reg <= 1'b0;
         pre_reg     <= {PSW{1'b0}};
         ext_q_reg   <= 1'b0;
         upd_reg     <= 1'b0;
         wrap_reg    <= 1'b0;
      end else begin
         ext_q_reg <= ext_f;
         upd_reg   <= tick & ~clr;
         wrap_reg  <= tick & at_lim & ~clr;
         if (clr) begin
            pre_reg <= {PSW{1'b0}}; // RULE23
            cnt_reg <= 16'h0000;
         end else begin
            if (run) begin
               pre_reg <= pre_reg + {{(PSW-1){1'b0}}, 1'b1};
            end
            if (tick) begin
               cnt_reg <= at_lim ? 16'h0000 : cnt_reg + 16'h0001; // RULE24
            end
         end
         if (w_sc) begin
            oie_reg  <= hwdata[`TMA_SC_OIE];
            halt_reg <= hwdata[`TMA_SC_HALT];
            ps_reg   <= hwdata[`TMA_PS_MSB:`TMA_PS_LSB];
         end
         if (w_modh) begin
            mod_reg[15:8] <= hwdata[7:0];
            mod_inh_reg   <= 1'b1; // RULE24
         end
         if (w_modl) begin
            mod_reg[7:0] <= hwdata[7:0];
            mod_inh_reg  <= 1'b0;
         end
      end
   end

   // ============================================================
   // Channel registers
   reg  [6:0]     csc_reg [0:NCH-1];
   reg  [15:0]    val_reg [0:NCH-1];
   reg  [NCH-1:0] lock_reg;
   reg  [NCH:0]   flag_reg;
   wire [NCH-1:0] cap_w;
   wire [NCH-1:0] evt_w;
   wire [NCH-1:0] done_w;
   integer j;

   // A capture wins over a bus write in the same cycle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_reg <= {NCH{1'b0}};
         for (j = 0; j < NCH; j = j + 1) begin
            csc_reg[j] <= `TMA_CSC_RST;
            val_reg[j] <= `TMA_VAL_RST;
         end
      end else begin
         for (j = 0; j < NCH; j = j + 1) begin
            if (w_csc && ({29'd0, wci} == j)) begin
               csc_reg[j] <= hwdata[6:0]; // RULE6
            end
            if (cap_w[j]) begin
               val_reg[j] <= cnt_reg;
            end else if (w_chh && ({29'd0, wci} == j)) begin
               val_reg[j][15:8] <= hwdata[7:0];
               lock_reg[j]      <= 1'b1; // RULE25
            end else if (w_chl && ({29'd0, wci} == j)) begin
               val_reg[j][7:0] <= hwdata[7:0];
               lock_reg[j]     <= 1'b0; // RULE25
            end
         end
      end
   end

   // ============================================================
   // Pair hand-over
   reg  [NP-1:0] act_reg;
   reg  [NP-1:0] pend_reg;
   reg  [NP-1:0] lnkq_reg;
   wire [NP-1:0] link_w;
   wire [NP-1:0] odd_done;
   wire [NP-1:0] even_done;
   // Still linked and not in the first linked cycle
   wire [NP-1:0] keep   = link_w & lnkq_reg;
   wire [NP-1:0] pnd_nx = (pend_reg | odd_done) & ~even_done; // RULE3
   wire [NP-1:0] act_nx = wrap_reg ? pnd_nx : act_reg;

   // Fresh link restarts on the even channel
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act_reg  <= {NP{1'b0}};
         pend_reg <= {NP{1'b0}};
         lnkq_reg <= {NP{1'b0}};
      end else begin
         lnkq_reg <= link_w;
         pend_reg <= pnd_nx & keep;
         act_reg  <= act_nx & keep; // RULE2 RULE3
      end
   end

   // ============================================================
   // Channel logic
   genvar i;
   generate
      for (i = 0; i < NCH; i = i + 1) begin : g_ch
         wire        rel;
         wire        own;
         wire [15:0] cmp;
         wire        cok;
         wire        oc;
         wire        ic;
         assign done_w[i] = w_chl & ({29'd0, wci} == i);
         if (i % 2 == 0) begin : g_ev
            // Link bit overrides the unbuffered bit
            assign own = csc_reg[i][`TMA_CSC_BUF]; // RULE10
            assign rel = 1'b0;
            assign link_w[i/2]    = own; // RULE1
            assign even_done[i/2] = done_w[i];
            assign cmp = (own & act_reg[i/2]) ? val_reg[i+1] : val_reg[i];
            assign cok = (own & act_reg[i/2]) ? ~lock_reg[i+1] : ~lock_reg[i];
         end else begin : g_od
            // Odd half of a linked pair is idle, its pin goes back to the port
            assign own = 1'b0;
            assign rel = csc_reg[i-1][`TMA_CSC_BUF]; // RULE4
            assign odd_done[i/2] = done_w[i];
            assign cmp = val_reg[i];
            assign cok = ~lock_reg[i];
         end
         assign oc = (csc_reg[i][`TMA_CSC_BUF] | csc_reg[i][`TMA_CSC_UNB]) & ~rel; // RULE6
         assign ic = ~csc_reg[i][`TMA_CSC_BUF] & ~csc_reg[i][`TMA_CSC_UNB] & ~rel
                   & (csc_reg[i][`TMA_CSC_ELSH:`TMA_CSC_ELSL] != 2'h0);
         assign chan_pin_oe[i] = oc; // RULE4
         assign channel_irq[i] = flag_reg[i] & csc_reg[i][`TMA_CSC_IE]; // RULE14

         tma_chan u_chan (
            .clk     (hclk),
            .rstn    (hresetn),
            .oc_en   (oc),
            .ic_en   (ic),
            .els     (csc_reg[i][`TMA_CSC_ELSH:`TMA_CSC_ELSL]),
            .tov     (csc_reg[i][`TMA_CSC_TOV]),
            .full    (csc_reg[i][`TMA_CSC_MAX]),
            .upd     (upd_reg),
            .wrap    (wrap_reg),
            .cnt     (cnt_reg),
            .cmp     (cmp),
            .cmp_ok  (cok),
            .pin_f   (pin_f[i]),
            .cap_blk (debug_break | halt_reg | stop_mode), // RULE17
            .pin_out (chan_pin_out[i]),
            .evt     (evt_w[i]),
            .cap     (cap_w[i])
         );
      end
   endgenerate

   // ============================================================
   // Status flags with two-step clear; bit NCH is the overflow flag
   reg  [NCH:0] arm_reg;
   wire [NCH:0] rd_w;
   wire [NCH:0] w0_w;
   wire         clr_ok = ~debug_break | break_clear_permit; // RULE18
   wire [NCH:0] okv    = {(NCH+1){clr_ok}};
   wire [NCH:0] set_w  = {wrap_reg & ~mod_inh_reg, evt_w}; // RULE13 RULE24

   assign rd_w[OVF] = rd_a & (ra == `TMA_SC_OFS);
   assign w0_w[OVF] = w_sc & ~hwdata[`TMA_SC_FLAG];
   generate
      for (i = 0; i < NCH; i = i + 1) begin : g_fl
         assign rd_w[i] = rch & ({29'd0, rci} == i) & (ra[3:2] == `TMA_CSC_SUB);
         assign w0_w[i] = w_csc & ({29'd0, wci} == i) & ~hwdata[`TMA_CSC_FLAG];
      end
   endgenerate

   // Set beats clear; a new event also disarms a pending clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_reg <= {(NCH+1){1'b0}};
         arm_reg  <= {(NCH+1){1'b0}};
      end else begin
         flag_reg <= set_w | (flag_reg & ~(w0_w & arm_reg & okv)); // RULE21 RULE18
         arm_reg  <= ~set_w & ((arm_reg & ~(w0_w & okv)) // RULE19
                  | (rd_w & flag_reg & okv)); // RULE21
      end
   end

   // Any enabled request also serves as the wake-up from wait
   assign overflow_irq = flag_reg[OVF] & oie_reg; // RULE13
   assign timer_irq    = overflow_irq | (|channel_irq); // RULE15

   // ============================================================
   // Read mux, sampled in the address phase
   always @* begin
      rd_next = 32'h00000000;
      if (ra == `TMA_SC_OFS) begin
         rd_next[7:0] = {flag_reg[OVF], oie_reg, halt_reg, 1'b0, 1'b0, ps_reg}; // RULE23
      end else if (ra == `TMA_CNT_OFS) begin
         rd_next[15:0] = cnt_reg;
      end else if (ra == `TMA_MODH_OFS) begin
         rd_next[7:0] = mod_reg[15:8];
      end else if (ra == `TMA_MODL_OFS) begin
         rd_next[7:0] = mod_reg[7:0];
      end else if (ch_ok(ra)) begin
         if (ra[3:2] == `TMA_CSC_SUB) begin
            rd_next[7:0] = {flag_reg[rci], csc_reg[rci]};
         end else if (ra[3:2] == `TMA_CHH_SUB) begin
            rd_next[7:0] = val_reg[rci][15:8];
         end else begin
            rd_next[7:0] = val_reg[rci][7:0];
         end
      end
   end

   // Zero-wait slave: writes land at the end of the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dsel_reg   <= 1'b0;
         dadr_reg   <= 8'h00;
         hrdata_reg <= 32'h00000000;
      end else begin
         dsel_reg   <= acc & hwrite;
         hrdata_reg <= rd_a ? rd_next : 32'h00000000;
         if (acc) begin
            dadr_reg <= ra;
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;
endmodule // tma_top

// ---- dv/tma_chk_assertions.sv ----
`timescale 1ns/1ps
// ============================================================
// Port-level checker for the timer block
module tma_chk #(
   parameter NCH = 6,
   parameter PSW = 7
) (
   // Clock and reset
   input wire           hclk,
   input wire           hresetn,
   // Bus
   input wire           hsel,
   input wire [31:0]    haddr,
   input wire [1:0]     htrans,
   input wire           hwrite,
   input wire           hready,
   input wire           hreadyout,
   input wire [31:0]    hrdata,
   input wire           hresp,
   // System state
   input wire           wait_mode,
   input wire           stop_mode,
   // Requests and pins
   input wire           overflow_irq,
   input wire [NCH-1:0] channel_irq,
   input wire           timer_irq,
   input wire [NCH-1:0] chan_pin_out
);
   logic [1:0] wr_q;
   wire        wr_now = hsel & htrans[1] & hready & ~wait_mode & hwrite;
   // Writes land a cycle late, so keep two cycles of history
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) wr_q <= 2'h0;
      else wr_q <= {wr_q[0], wr_now};
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   irq_merge_a: assert property (timer_irq == (overflow_irq | (|channel_irq)))
      else $error("wake request differs from the merged requests");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus slave stalled or erred");
   rd_idle_a: assert property (!$past(hsel & htrans[1] & hready & ~hwrite) |-> hrdata == 32'h0)
      else $error("read data outside a data phase");
   wait_rd_a: assert property (hsel && htrans[1] && !hwrite && wait_mode |=> hrdata == 32'h0)
      else $error("register read during wait");
   unmap_rd_a: assert property (hsel && htrans[1] && !hwrite && haddr[31:8] != 24'h0
      |=> hrdata == 32'h0)
      else $error("unmapped read returned data");
   stop_hold_a: assert property ((stop_mode && wr_q == 2'h0)[*4] |->
      $stable(chan_pin_out) && $stable(overflow_irq) && $stable(channel_irq))
      else $error("timer state moved in stop");
   irq_fall_a: assert property ($fell(overflow_irq) |-> wr_q != 2'h0)
      else $error("overflow request dropped with no write");
   chan_fall_a: assert property (|($past(channel_irq) & ~channel_irq) |-> wr_q != 2'h0)
      else $error("channel request dropped with no write");
   // Main scenarios
   cover property ($rose(overflow_irq));
   cover property ($rose(channel_irq[0]));
   cover property (stop_mode[*4]);
endmodule // tma_chk

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the timer block
module testbench;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        wait_mode = 1'b0;
   logic        stop_mode = 1'b0;
   logic        debug_break = 1'b0;
   logic        break_clear_permit = 1'b0;
   logic        ext_pin = 1'b0;
   logic [5:0]  pin_in = 6'h0;
   wire         hreadyout;
   wire         hresp;
   wire         ovf_irq;
   wire         tmr_irq;
   wire [31:0]  hrdata;
   wire [5:0]   ch_irq;
   wire [5:0]   chan_pin_out;
   wire [5:0]   chan_pin_oe;
   int          bad_count = 0;
   int          samples_checked = 0;
   logic [31:0] rv;
   logic [31:0] rv2;
   // Rows: write flag, address, data, expected read
   logic [31:0] rows [10];
   always #4 hclk = ~hclk;
   tma_top u_tma_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .wait_mode(wait_mode), .stop_mode(stop_mode), .debug_break(debug_break),
      .break_clear_permit(break_clear_permit), .overflow_irq(ovf_irq),
      .channel_irq(ch_irq), .timer_irq(tmr_irq), .ext_count_clock_pin(ext_pin),
      .chan_pin_in(pin_in), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe)
   );
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One single transfer; starts and ends just after a rising edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [31:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // High cycles of one pin over a full 16-count period
   task automatic duty(input int p);
      rv = 32'h0;
      repeat (16) begin
         @(posedge hclk);
         rv = rv + chan_pin_out[p];
      end
   endtask
   task automatic test_done;
      $display("checks=%0d errors=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Hang guard, far beyond the nine hundred or so cycles needed
   initial begin
      #400000;
      bad_count++;
      test_done;
   end
   initial begin
      rows = '{32'h0_000_00_20, 32'h0_008_00_FF, 32'h0_00C_00_FF, 32'h0_010_00_00,
               32'h0_014_00_00, 32'h1_010_3F_3F, 32'h1_010_00_00, 32'h1_100_55_00,
               32'h1_000_37_27, 32'h1_000_20_20};
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk({tmr_irq, chan_pin_oe}, 32'h0);
      foreach (rows[i]) begin
         if (rows[i][28]) wr({20'h0, rows[i][27:16]}, {24'h0, rows[i][15:8]});
         rd({20'h0, rows[i][27:16]});
         chk(rv, {24'h0, rows[i][7:0]});
      end
      // Buffered pair 0/1, period 16, clear on compare
      wr(32'h00, 32'h30);
      wr(32'h08, 32'h00);
      wr(32'h0C, 32'h0F);
      wr(32'h18, 32'h04);
      wr(32'h10, 32'h6A);
      wr(32'h00, 32'h00);
      cyc(40);
      duty(0);
      chk(rv, 32'h4);
      chk(chan_pin_oe[1:0], 32'h1);
      chk(ch_irq[0], 32'h1);
      wr(32'h28, 32'h0C);
      cyc(40);
      duty(0);
      chk(rv, 32'hC);
      wr(32'h18, 32'h08);
      cyc(40);
      duty(0);
      chk(rv, 32'h8);
      // Overflow flag and its two-step clear
      wr(32'h00, 32'h20);
      cyc(2);
      rd(32'h00);
      chk(rv, 32'hA0);
      wr(32'h00, 32'h60);
      rd(32'h00);
      chk(rv, 32'h60);
      chk(ovf_irq, 32'h0);
      wr(32'h00, 32'h40);
      cyc(20);
      chk(ovf_irq, 32'h1);
      rd(32'h00);
      cyc(20);
      wr(32'h00, 32'h40);
      rd(32'h00);
      chk(rv, 32'hC0);
      // Debug break freezes the counter
      debug_break <= 1'b1;
      cyc(2);
      rd(32'h04);
      rv2 = rv;
      cyc(8);
      rd(32'h04);
      chk(rv, rv2);
      debug_break <= 1'b0;
      cyc(20);
      wr(32'h00, 32'h60);
      cyc(2);
      rd(32'h00);
      chk(rv, 32'hE0);
      // Armed before the break, held in it, cleared after it
      debug_break <= 1'b1;
      wr(32'h00, 32'h60);
      rd(32'h00);
      chk(rv, 32'hE0);
      debug_break <= 1'b0;
      wr(32'h00, 32'h60);
      rd(32'h00);
      chk(rv, 32'h60);
      // Stop keeps the count, then counting resumes
      wr(32'h00, 32'h40);
      cyc(4);
      stop_mode <= 1'b1;
      cyc(2);
      rd(32'h04);
      rv2 = rv;
      cyc(10);
      rd(32'h04);
      chk(rv, rv2);
      stop_mode <= 1'b0;
      cyc(4);
      rd(32'h04);
      chk(rv !== rv2, 32'h1);
      // Registers shut off in wait, timer still requests
      wait_mode <= 1'b1;
      rd(32'h00);
      chk(rv, 32'h0);
      chk(tmr_irq, 32'h1);
      wait_mode <= 1'b0;
      // Full and zero duty on every pair output
      for (int p = 0; p < 6; p += 2) begin
         wr(32'h10 + 32'h10 * p, 32'h2B);
         cyc(40);
         duty(p);
         chk(rv, 32'h10);
         chk(chan_pin_oe[p+1], 32'h0);
         wr(32'h10 + 32'h10 * p, 32'h28);
         cyc(40);
         duty(p);
         chk(rv, 32'h0);
      end
      // Capture on channel 4 once its old flag is cleared
      wr(32'h50, 32'h04);
      cyc(2);
      rd(32'h50);
      wr(32'h50, 32'h04);
      pin_in <= 6'h10;
      cyc(8);
      rd(32'h50);
      chk(rv, 32'h84);
      // Unbuffered PWM on channel 2
      wr(32'h38, 32'h04);
      wr(32'h30, 32'h1A);
      cyc(40);
      duty(2);
      chk(rv, 32'h4);
      // Divide by 64: one tick in any 64-cycle window
      wr(32'h00, 32'h06);
      rd(32'h04);
      rv2 = rv;
      cyc(62);
      rd(32'h04);
      chk((rv - rv2) & 32'hF, 32'h1);
      // Pin clock: three rising edges, three counts
      wr(32'h00, 32'h07);
      rd(32'h04);
      rv2 = rv;
      repeat (3) begin
         ext_pin <= 1'b1;
         cyc(4);
         ext_pin <= 1'b0;
         cyc(4);
      end
      rd(32'h04);
      chk((rv - rv2) & 32'hF, 32'h3);
      test_done;
   end
endmodule // testbench
bind tma_top tma_chk #(.NCH(NCH), .PSW(PSW)) u_tma_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
   .hresp(hresp), .wait_mode(wait_mode), .stop_mode(stop_mode),
   .overflow_irq(overflow_irq), .channel_irq(channel_irq), .timer_irq(timer_irq),
   .chan_pin_out(chan_pin_out)
);
